// *** core/fault_warning_pkg.sv ***
/*
 * Shared constants and carrier types of the fault and warning manager.
 * Assumes a 32-bit APB master and a 200 MHz control clock.
 */
package fault_warning_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NCODE = 128;
	localparam int CODE_W = 7;
	localparam int HIST_DEPTH = 16;
	localparam int HIST_AW = 4;
	localparam int SEL_W = 8;
	localparam int LEN_W = 8;
	localparam int MISS_W = 3;
	localparam int WORD_AW = 2;
	localparam int ADDR_LSB = 2;
	localparam int GROUP_LSB = 4;
	localparam int HIST_LSB = 6;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] CMD_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] SYNC_OFS = 12'h00c;
	localparam logic [ADDR_W-1:0] MAPLEN_OFS = 12'h010;
	localparam logic [ADDR_W-1:0] HISTCNT_OFS = 12'h014;
	localparam logic [ADDR_W-1:0] FAULT_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] WARN_BASE = 12'h050;
	localparam logic [ADDR_W-1:0] HIST_BASE = 12'h080;

	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_ACLR_BIT = 1;
	localparam int CMD_CLEAR_BIT = 0;
	localparam int ST_READY_BIT = 0;
	localparam int ST_REMOTE_BIT = 1;
	localparam int ST_DRIVE_BIT = 2;
	localparam int ST_FATAL_BIT = 3;
	localparam int ST_WARN_BIT = 4;
	localparam int ST_FAULT_BIT = 5;

	// warning codes computed inside the block
	localparam int W_PLL = 11;
	localparam int W_HWPOS = 15;
	localparam int W_HWNEG = 16;
	localparam int W_HWBOTH = 17;
	localparam int W_SWPOS = 18;
	localparam int W_SWNEG = 19;
	localparam int W_SWBOTH = 20;
	localparam int W_PDOLONG = 41;
	localparam int W_PDOLOCK = 43;
	localparam int W_TGTLOST = 49;
	localparam int MISS_LIMIT = 3;

	localparam logic [NCODE-1:0] COMPUTED_MASK = (128'h1 << W_PLL) | (128'h1 << W_HWPOS)
		| (128'h1 << W_HWNEG) | (128'h1 << W_HWBOTH) | (128'h1 << W_SWPOS)
		| (128'h1 << W_SWNEG) | (128'h1 << W_SWBOTH) | (128'h1 << W_PDOLONG)
		| (128'h1 << W_PDOLOCK) | (128'h1 << W_TGTLOST);
	localparam logic [NCODE-1:0] FATAL_DEFAULT = (128'h1 << 38) | (128'h1 << 36) | (128'h1 << 37);

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic [DATA_W-1:0] prdata;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic valid;
		logic [HIST_AW-1:0] addr;
		logic [CODE_W-1:0] code;
	} nv_write_t;

	typedef struct packed {
		logic [NCODE-1:0] fltLatch;
		logic [NCODE-1:0] logged;
		logic [NCODE-1:0] warn;
		logic swEnable;
		logic alarmClearCfg;
		logic remotePrev;
		logic alarmPrev;
		logic [SEL_W-1:0] syncSel;
		logic [LEN_W-1:0] mapLen;
		logic warnPdoLong;
		logic warnPdoLock;
		logic [MISS_W-1:0] missCount;
		logic targetSeen;
		logic [HIST_DEPTH-1:0][CODE_W-1:0] hist;
		logic [HIST_AW-1:0] histWr;
		logic [HIST_AW:0] histCount;
		logic driveEnable;
		logic commsEnable;
		logic ready;
		logic pdoAccept;
		logic [CODE_W-1:0] displayCode;
		logic displayFault;
		nv_write_t nvWrite;
		apb_rsp_t rsp;
	} state_t;
endpackage : fault_warning_pkg

// *** core/fault_warning_manager.sv ***
/*
 * Fault and warning supervision with APB register access, latched faults,
 * clear sequences, fault history with a non-volatile write port and display code.
 * Assumes all inputs synchronous to clock; the NV memory accepts one write per pulse.
 */
// What this block does
// - warnings never disable the drive
// - warnings drop when their cause drops; 41 and 43 hold until the next packet or process data write
// - any fault disables drive, shows on outputs
// - faults latch; no enable until cleared
// - clear ignored while fault cause persists
// - disable then enable command clears faults
// - remote enable toggle clears faults
// - configured alarm-clear input toggle clears faults
// - drive re-enables after successful clear
// - fatal faults block comms and enabling
// - each fault appended to non-volatile history
// - clear-all command clears gone-cause faults
// - queries return latched faults and history
// - ready only when nothing blocks enabling
// - remote enable level readable
// - faults and chosen warnings drive display
// - hardware limit warnings 15, 16, 17
// - software limit warnings 18, 19, 20
// - warning 49 after 3 missed targets
// - warning 11 when sync selected, unlocked
// - warning 41 on too long packet
// - warning 43 and discard locked writes
`timescale 1ns/10ps
module fault_warning_manager
	import fault_warning_pkg::*;
#(
	parameter logic [NCODE-1:0] FATAL_MASK = FATAL_DEFAULT,
	parameter logic [NCODE-1:0] WARN_DISPLAY_MASK = {NCODE{1'b1}}
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic clockEnable,
	input wire apb_req_t apbReq,
	output apb_rsp_t apbRsp,
	input wire logic [NCODE-1:0] faultCond,
	input wire logic [NCODE-1:0] warnCond,
	input wire logic remoteEnable,
	input wire logic alarmClearIn,
	input wire logic hwPosOpen,
	input wire logic hwNegOpen,
	input wire logic swPosTrip,
	input wire logic swNegTrip,
	input wire logic pllLocked,
	input wire logic targetSlot,
	input wire logic targetRcvd,
	input wire logic pdoRcvd,
	input wire logic [LEN_W-1:0] pdoLength,
	input wire logic pdoWrite,
	output logic driveEnable,
	output logic commsEnable,
	output logic ready,
	output logic pdoAccept,
	output logic [CODE_W-1:0] displayCode,
	output logic displayFault,
	output nv_write_t nvWrite
);
	state_t state_q;
	state_t state_d;

	function automatic logic [CODE_W:0] lowestSet(input logic [NCODE-1:0] v);
		logic [CODE_W:0] r;
		r = '0;
		for (int i = NCODE - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, CODE_W'(i)};
			end
		end
		return r;
	endfunction : lowestSet

	////////////////////////////////////////////////////////////////////////
	logic setupPhase;
	logic accessWrite;
	logic writeAllowed;
	logic clearAllCmd;
	logic swEnableRise;
	logic remoteRise;
	logic alarmToggle;
	logic clearReq;
	logic [NCODE-1:0] pending;
	logic [CODE_W:0] nextLog;
	logic [CODE_W:0] firstFault;
	logic [CODE_W:0] firstWarn;
	logic [NCODE-1:0] warnNext;
	logic [DATA_W-1:0] readData;
	logic readErr;

	always_comb begin
		state_d = state_q;
		setupPhase = apbReq.psel & ~apbReq.penable & ~state_q.rsp.pready;
		accessWrite = apbReq.psel & apbReq.penable & state_q.rsp.pready & apbReq.pwrite;
		writeAllowed = accessWrite & state_q.commsEnable;
		clearAllCmd = 1'b0;

		// register writes
		if (writeAllowed) begin
			if (apbReq.paddr == CTRL_OFS) begin
				state_d.swEnable = apbReq.pwdata[CTRL_EN_BIT];
				state_d.alarmClearCfg = apbReq.pwdata[CTRL_ACLR_BIT];
			end else if (apbReq.paddr == CMD_OFS) begin
				clearAllCmd = apbReq.pwdata[CMD_CLEAR_BIT];
			end else if (apbReq.paddr == SYNC_OFS) begin
				state_d.syncSel = apbReq.pwdata[SEL_W-1:0];
			end else if (apbReq.paddr == MAPLEN_OFS) begin
				state_d.mapLen = apbReq.pwdata[LEN_W-1:0];
			end
		end

		// clear sources
		swEnableRise = state_d.swEnable & ~state_q.swEnable;
		remoteRise = remoteEnable & ~state_q.remotePrev;
		alarmToggle = state_q.alarmClearCfg & (alarmClearIn ^ state_q.alarmPrev);
		state_d.remotePrev = remoteEnable;
		state_d.alarmPrev = alarmClearIn;
		clearReq = swEnableRise | remoteRise | alarmToggle | clearAllCmd;

		// latch: set wins over clear, live causes and fatal faults stay
		state_d.fltLatch = faultCond;
		if (clearReq) begin
			state_d.fltLatch = state_d.fltLatch
				| (state_q.fltLatch & (faultCond | FATAL_MASK));
		end else begin
			state_d.fltLatch = state_d.fltLatch | state_q.fltLatch;
		end

		// history append, one code per cycle, lowest first
		pending = state_q.fltLatch & ~state_q.logged;
		nextLog = lowestSet(pending);
		state_d.logged = state_q.logged & state_d.fltLatch;
		state_d.nvWrite.valid = nextLog[CODE_W];
		state_d.nvWrite.addr = state_q.histWr;
		state_d.nvWrite.code = nextLog[CODE_W-1:0];
		if (nextLog[CODE_W]) begin
			state_d.hist[state_q.histWr] = nextLog[CODE_W-1:0];
			state_d.histWr = state_q.histWr + 1'b1;
			state_d.logged[nextLog[CODE_W-1:0]] = 1'b1;
			if (state_q.histCount != (HIST_AW + 1)'(HIST_DEPTH)) begin
				state_d.histCount = state_q.histCount + 1'b1;
			end
		end

		// target-command supervision
		if (targetSlot) begin
			if (state_q.targetSeen | targetRcvd) begin
				state_d.missCount = '0;
			end else if (state_q.missCount != MISS_W'(MISS_LIMIT)) begin
				state_d.missCount = state_q.missCount + 1'b1;
			end
			state_d.targetSeen = 1'b0;
		end else begin
			state_d.targetSeen = state_q.targetSeen | targetRcvd;
		end

		// process data checks
		if (pdoRcvd) begin
			state_d.warnPdoLong = pdoLength > state_q.mapLen;
		end
		if (pdoWrite) begin
			state_d.warnPdoLock = state_q.driveEnable;
		end
		state_d.pdoAccept = pdoWrite & ~state_q.driveEnable;

		// warnings: recomputed every cycle; 41 and 43 hold until the next packet or process data write
		warnNext = warnCond & ~COMPUTED_MASK;
		warnNext[W_HWPOS] = hwPosOpen & ~hwNegOpen;
		warnNext[W_HWNEG] = hwNegOpen & ~hwPosOpen;
		warnNext[W_HWBOTH] = hwPosOpen & hwNegOpen;
		warnNext[W_SWPOS] = swPosTrip & ~swNegTrip;
		warnNext[W_SWNEG] = swNegTrip & ~swPosTrip;
		warnNext[W_SWBOTH] = swPosTrip & swNegTrip;
		warnNext[W_PLL] = (state_d.syncSel != '0) & ~pllLocked;
		warnNext[W_PDOLONG] = state_d.warnPdoLong;
		warnNext[W_PDOLOCK] = state_d.warnPdoLock;
		warnNext[W_TGTLOST] = state_d.missCount >= MISS_W'(MISS_LIMIT);
		state_d.warn = warnNext;

		// enables: warnings take no part
		state_d.driveEnable = state_d.swEnable & remoteEnable
			& (state_d.fltLatch == '0);
		state_d.commsEnable = (state_d.fltLatch & FATAL_MASK) == '0;
		state_d.ready = (state_d.fltLatch == '0) & remoteEnable;

		// display: faults first, then displayable warnings
		firstFault = lowestSet(state_d.fltLatch);
		firstWarn = lowestSet(state_d.warn & WARN_DISPLAY_MASK);
		state_d.displayFault = firstFault[CODE_W];
		if (firstFault[CODE_W]) begin
			state_d.displayCode = firstFault[CODE_W-1:0];
		end else if (firstWarn[CODE_W]) begin
			state_d.displayCode = firstWarn[CODE_W-1:0];
		end else begin
			state_d.displayCode = '0;
		end

		// read decode, answered one cycle after setup
		readData = '0;
		readErr = 1'b0;
		if (apbReq.paddr == CTRL_OFS) begin
			readData[CTRL_EN_BIT] = state_q.swEnable;
			readData[CTRL_ACLR_BIT] = state_q.alarmClearCfg;
		end else if (apbReq.paddr == CMD_OFS) begin
			readData = '0;
		end else if (apbReq.paddr == STATUS_OFS) begin
			readData[ST_READY_BIT] = state_q.ready;
			readData[ST_REMOTE_BIT] = remoteEnable;
			readData[ST_DRIVE_BIT] = state_q.driveEnable;
			readData[ST_FATAL_BIT] = ~state_q.commsEnable;
			readData[ST_WARN_BIT] = state_q.warn != '0;
			readData[ST_FAULT_BIT] = state_q.fltLatch != '0;
		end else if (apbReq.paddr == SYNC_OFS) begin
			readData[SEL_W-1:0] = state_q.syncSel;
		end else if (apbReq.paddr == MAPLEN_OFS) begin
			readData[LEN_W-1:0] = state_q.mapLen;
		end else if (apbReq.paddr == HISTCNT_OFS) begin
			readData[HIST_AW:0] = state_q.histCount;
		end else if (apbReq.paddr[ADDR_W-1:GROUP_LSB] == FAULT_BASE[ADDR_W-1:GROUP_LSB]) begin
			readData = state_q.fltLatch[DATA_W*apbReq.paddr[ADDR_LSB +: WORD_AW] +: DATA_W];
		end else if (apbReq.paddr[ADDR_W-1:GROUP_LSB] == WARN_BASE[ADDR_W-1:GROUP_LSB]) begin
			readData = state_q.warn[DATA_W*apbReq.paddr[ADDR_LSB +: WORD_AW] +: DATA_W];
		end else if (apbReq.paddr[ADDR_W-1:HIST_LSB] == HIST_BASE[ADDR_W-1:HIST_LSB]) begin
			readData[CODE_W-1:0] = state_q.hist[apbReq.paddr[ADDR_LSB +: HIST_AW]];
		end else begin
			readErr = 1'b1;
		end
		if (apbReq.paddr[ADDR_LSB-1:0] != '0) begin
			readErr = 1'b1;
		end

		state_d.rsp.pready = setupPhase;
		state_d.rsp.prdata = setupPhase & ~apbReq.pwrite ? readData : '0;
		state_d.rsp.pslverr = setupPhase & (readErr | (apbReq.pwrite & ~state_q.commsEnable));
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_q <= '0;
			state_q.commsEnable <= 1'b1;
		end else if (clockEnable) begin
			state_q <= state_d;
		end
	end

	assign apbRsp = state_q.rsp;
	assign driveEnable = state_q.driveEnable;
	assign commsEnable = state_q.commsEnable;
	assign ready = state_q.ready;
	assign pdoAccept = state_q.pdoAccept;
	assign displayCode = state_q.displayCode;
	assign displayFault = state_q.displayFault;
	assign nvWrite = state_q.nvWrite;

	////////////////////////////////////////////////////////////////////////
	property p_fault_disables;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && faultCond != '0) |=> (!driveEnable && displayFault);
	endproperty
	a_fault_disables: assert property (p_fault_disables) else $error("fault left drive on");

	property p_live_cause_kept;
		@(posedge clock) disable iff (!resetn)
		clockEnable |=> ((state_q.fltLatch & $past(faultCond)) == $past(faultCond));
	endproperty
	a_live_cause_kept: assert property (p_live_cause_kept) else $error("live fault dropped");

	property p_latch_holds;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && state_q.fltLatch != '0 && !remoteEnable && !alarmClearIn
			&& !alarmToggle && !clearAllCmd && !swEnableRise && !remoteRise)
		|=> (state_q.fltLatch != '0) && !driveEnable;
	endproperty
	a_latch_holds: assert property (p_latch_holds) else $error("latched fault vanished");

	property p_hw_limit_codes;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && hwPosOpen && hwNegOpen)
		|=> state_q.warn[W_HWBOTH] && !state_q.warn[W_HWPOS] && !state_q.warn[W_HWNEG];
	endproperty
	a_hw_limit_codes: assert property (p_hw_limit_codes) else $error("limit code wrong");

	property p_warn_self_clears;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && !swPosTrip && !swNegTrip) |=> (state_q.warn[W_SWBOTH:W_SWPOS] == '0);
	endproperty
	a_warn_self_clears: assert property (p_warn_self_clears) else $error("warning stuck");

	property p_pll_warn;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && state_q.syncSel != '0 && !pllLocked && !writeAllowed) |=> state_q.warn[W_PLL];
	endproperty
	a_pll_warn: assert property (p_pll_warn) else $error("pll warning missing");

	property p_ready_clean;
		@(posedge clock) disable iff (!resetn)
		ready |-> (state_q.fltLatch == '0) && commsEnable;
	endproperty
	a_ready_clean: assert property (p_ready_clean) else $error("ready with fault");

	property p_fatal_blocks;
		@(posedge clock) disable iff (!resetn)
		(!commsEnable) |-> (!driveEnable && !ready);
	endproperty
	a_fatal_blocks: assert property (p_fatal_blocks) else $error("fatal did not block");

	property p_target_lost;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && targetSlot && !targetRcvd && !state_q.targetSeen
			&& state_q.missCount == MISS_W'(MISS_LIMIT - 1)) |=> state_q.warn[W_TGTLOST];
	endproperty
	a_target_lost: assert property (p_target_lost) else $error("target loss not flagged");

	property p_locked_write;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && pdoWrite && driveEnable) |=> (!pdoAccept && state_q.warn[W_PDOLOCK]);
	endproperty
	a_locked_write: assert property (p_locked_write) else $error("locked write accepted");

	property p_history_append;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && (state_q.fltLatch & ~state_q.logged) != '0) |=> nvWrite.valid;
	endproperty
	a_history_append: assert property (p_history_append) else $error("fault not logged");

	property p_warn_no_disable;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && state_q.fltLatch == '0 && faultCond == '0 && state_q.swEnable
			&& remoteEnable && !writeAllowed) |=> driveEnable;
	endproperty
	a_warn_no_disable: assert property (p_warn_no_disable) else $error("warning disabled drive");

	property p_cmd_clear;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && swEnableRise && faultCond == '0 && (state_q.fltLatch & FATAL_MASK) == '0)
		|=> (state_q.fltLatch == '0);
	endproperty
	a_cmd_clear: assert property (p_cmd_clear) else $error("command toggle did not clear");

	property p_remote_clear;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && remoteRise && faultCond == '0 && (state_q.fltLatch & FATAL_MASK) == '0)
		|=> (state_q.fltLatch == '0);
	endproperty
	a_remote_clear: assert property (p_remote_clear) else $error("remote toggle did not clear");

	property p_alarm_clear;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && alarmToggle && faultCond == '0 && (state_q.fltLatch & FATAL_MASK) == '0)
		|=> (state_q.fltLatch == '0);
	endproperty
	a_alarm_clear: assert property (p_alarm_clear) else $error("alarm toggle did not clear");

	property p_clear_all;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && clearAllCmd && faultCond == '0 && (state_q.fltLatch & FATAL_MASK) == '0)
		|=> (state_q.fltLatch == '0);
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear all left a fault");

	property p_reenable;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && clearReq && faultCond == '0 && (state_q.fltLatch & FATAL_MASK) == '0
			&& state_d.swEnable && remoteEnable) |=> driveEnable;
	endproperty
	a_reenable: assert property (p_reenable) else $error("drive not re-enabled");

	property p_display_fault;
		@(posedge clock) disable iff (!resetn)
		displayFault |-> state_q.fltLatch[displayCode];
	endproperty
	a_display_fault: assert property (p_display_fault) else $error("display shows wrong fault");

	property p_display_warn;
		@(posedge clock) disable iff (!resetn)
		(state_q.fltLatch == '0 && (state_q.warn & WARN_DISPLAY_MASK) != '0)
		|-> (!displayFault && state_q.warn[displayCode]);
	endproperty
	a_display_warn: assert property (p_display_warn) else $error("display shows wrong warning");

	property p_sw_limit_codes;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && swPosTrip && swNegTrip)
		|=> state_q.warn[W_SWBOTH] && !state_q.warn[W_SWPOS] && !state_q.warn[W_SWNEG];
	endproperty
	a_sw_limit_codes: assert property (p_sw_limit_codes) else $error("soft limit code wrong");

	property p_pdo_long;
		@(posedge clock) disable iff (!resetn)
		(clockEnable && pdoRcvd && pdoLength > state_q.mapLen) |=> state_q.warn[W_PDOLONG];
	endproperty
	a_pdo_long: assert property (p_pdo_long) else $error("long packet not flagged");
endmodule : fault_warning_manager

// *** tb/fault_host_model.sv ***
/*
 * Host model: issues register transfers over APB on behalf of the serial host.
 * Assumes the manager answers every access with pready and holds apbReq idle otherwise.
 */
`timescale 1ns/10ps
module fault_host_model
	import fault_warning_pkg::*;
(
	input wire logic clock,
	input wire apb_rsp_t apbRsp,
	output apb_req_t apbReq
);
	initial apbReq = '0;

	////////////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rdata, output logic err);
		@(posedge clock);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		// wait for pready; the bench timeout ends the wait only if it never comes
		do begin
			@(posedge clock);
		end while (apbRsp.pready !== 1'b1);
		rdata = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
	endtask : xfer

	// disable then enable command pair
	task automatic clearByToggle(input logic [DATA_W-1:0] ctrl);
		logic [DATA_W-1:0] r;
		logic e;
		xfer(1'b1, CTRL_OFS, ctrl & ~32'h1, r, e);
		xfer(1'b1, CTRL_OFS, ctrl, r, e);
	endtask : clearByToggle
endmodule : fault_host_model

// *** tb/fault_warning_manager_tb_top.sv ***
/*
 * Self-checking bench of the fault and warning manager.
 * Assumes the host model drives APB and the bench drives all other inputs.
 */
`timescale 1ns/10ps
module fault_warning_manager_tb_top
	import fault_warning_pkg::*;
;
	logic clock, resetn, clockEnable, remoteEnable, alarmClearIn;
	logic hwPosOpen, hwNegOpen, swPosTrip, swNegTrip, pllLocked;
	logic targetSlot, targetRcvd, pdoRcvd, pdoWrite;
	logic [LEN_W-1:0] pdoLength;
	logic [NCODE-1:0] faultCond, warnCond;
	logic driveEnable, commsEnable, ready, pdoAccept, displayFault;
	logic [CODE_W-1:0] displayCode;
	nv_write_t nvWrite;
	apb_req_t apbReq;
	apb_rsp_t apbRsp;
	int badCount = 0;
	int nTests = 0;
	int cycles = 0;

	fault_host_model u_host (.clock(clock), .apbRsp(apbRsp), .apbReq(apbReq));

	fault_warning_manager u_dut (.clock(clock), .resetn(resetn), .clockEnable(clockEnable),
		.apbReq(apbReq), .apbRsp(apbRsp), .faultCond(faultCond), .warnCond(warnCond),
		.remoteEnable(remoteEnable), .alarmClearIn(alarmClearIn), .hwPosOpen(hwPosOpen),
		.hwNegOpen(hwNegOpen), .swPosTrip(swPosTrip), .swNegTrip(swNegTrip),
		.pllLocked(pllLocked), .targetSlot(targetSlot), .targetRcvd(targetRcvd),
		.pdoRcvd(pdoRcvd), .pdoLength(pdoLength), .pdoWrite(pdoWrite),
		.driveEnable(driveEnable), .commsEnable(commsEnable), .ready(ready),
		.pdoAccept(pdoAccept), .displayCode(displayCode), .displayFault(displayFault),
		.nvWrite(nvWrite));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		nTests++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		logic e;
		u_host.xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdChk(input string what, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] r;
		logic e;
		u_host.xfer(1'b0, a, '0, r, e);
		chk(what, r, exp);
	endtask : rdChk

	task automatic summarize();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////////////
	task automatic tEnable();
		chk("commsEnable", 32'(commsEnable), 32'h1);
		wr(CTRL_OFS, 32'h1);
		step(2);
		chk("driveEnable", 32'(driveEnable), 32'h1);
		rdChk("status", STATUS_OFS, 32'h7);
	endtask : tEnable

	task automatic tWarn();
		@(posedge clock) warnCond <= 128'h20;
		step(2);
		chk("drive with warning", 32'(driveEnable), 32'h1);
		chk("display warning", 32'({displayFault, displayCode}), 32'h5);
		rdChk("warn word", WARN_BASE, 32'h20);
		@(posedge clock) warnCond <= '0;
		step(2);
		rdChk("warn gone", WARN_BASE, 32'h0);
	endtask : tWarn

	task automatic tCodes();
		wr(SYNC_OFS, 32'h1);
		for (int i = 1; i < 4; i++) begin
			@(posedge clock);
			pllLocked <= 1'b0;
			{hwNegOpen, hwPosOpen} <= 2'(i);
			{swNegTrip, swPosTrip} <= 2'(i);
			step(2);
			rdChk("limit codes", WARN_BASE,
				32'h800 | (32'h1 << (14 + i)) | (32'h1 << (17 + i)));
		end
		@(posedge clock);
		{hwNegOpen, hwPosOpen, swNegTrip, swPosTrip} <= 4'h0;
		pllLocked <= 1'b1;
	endtask : tCodes

	task automatic tFaultCmd();
		@(posedge clock) faultCond <= 128'h8;
		step(1);
		chk("drive off", 32'(driveEnable), 32'h0);
		chk("display fault", 32'({displayFault, displayCode}), 32'h83);
		step(1);
		chk("history write", 32'({nvWrite.valid, nvWrite.addr, nvWrite.code}), 32'h803);
		u_host.clearByToggle(32'h1);
		step(2);
		rdChk("still latched", FAULT_BASE, 32'h8);
		@(posedge clock) faultCond <= '0;
		step(2);
		chk("latched off", 32'(driveEnable), 32'h0);
		chk("not ready", 32'(ready), 32'h0);
		u_host.clearByToggle(32'h1);
		step(2);
		chk("re-enabled", 32'(driveEnable), 32'h1);
	endtask : tFaultCmd

	task automatic tRemote();
		@(posedge clock) faultCond <= 128'h10;
		step(2);
		@(posedge clock);
		faultCond <= '0;
		remoteEnable <= 1'b0;
		step(2);
		rdChk("remote low", STATUS_OFS, 32'h20);
		@(posedge clock) remoteEnable <= 1'b1;
		step(2);
		chk("remote clear", 32'(driveEnable), 32'h1);
	endtask : tRemote

	task automatic tAlarm();
		wr(CTRL_OFS, 32'h3);
		@(posedge clock) faultCond <= 128'h20;
		step(2);
		@(posedge clock) faultCond <= '0;
		step(2);
		chk("alarm held", 32'(driveEnable), 32'h0);
		@(posedge clock) alarmClearIn <= 1'b1;
		step(2);
		chk("alarm clear", 32'(driveEnable), 32'h1);
	endtask : tAlarm

	task automatic tClearAll();
		@(posedge clock) faultCond <= 128'hc0;
		step(2);
		@(posedge clock) faultCond <= 128'h80;
		step(1);
		wr(CMD_OFS, 32'h1);
		step(2);
		rdChk("partial clear", FAULT_BASE, 32'h80);
		@(posedge clock) faultCond <= '0;
		step(1);
		wr(CMD_OFS, 32'h1);
		step(2);
		rdChk("all clear", FAULT_BASE, 32'h0);
		chk("clear all enable", 32'(driveEnable), 32'h1);
		rdChk("history count", HISTCNT_OFS, 32'h5);
		rdChk("history first", HIST_BASE, 32'h3);
		rdChk("history fifth", HIST_BASE + 12'h010, 32'h7);
	endtask : tClearAll

	task automatic tProcessData();
		wr(MAPLEN_OFS, 32'h4);
		@(posedge clock);
		pdoRcvd <= 1'b1;
		pdoLength <= 8'h05;
		@(posedge clock);
		pdoRcvd <= 1'b0;
		pdoWrite <= 1'b1;
		@(posedge clock) pdoWrite <= 1'b0;
		#1;
		chk("write discarded", 32'(pdoAccept), 32'h0);
		repeat (3) begin
			@(posedge clock) targetSlot <= 1'b1;
			@(posedge clock) targetSlot <= 1'b0;
		end
		step(2);
		rdChk("fieldbus warnings", WARN_BASE + 12'h004, 32'h00020a00);
		@(posedge clock) {targetSlot, targetRcvd} <= 2'b11;
		@(posedge clock) {targetSlot, targetRcvd} <= 2'b00;
		step(2);
		rdChk("target back", WARN_BASE + 12'h004, 32'h00000a00);
	endtask : tProcessData

	task automatic tFreeze();
		@(posedge clock);
		clockEnable <= 1'b0;
		faultCond <= 128'h4;
		step(2);
		chk("frozen drive", 32'(driveEnable), 32'h1);
		chk("frozen display", 32'(displayFault), 32'h0);
		@(posedge clock);
		clockEnable <= 1'b1;
		faultCond <= '0;
		step(2);
		rdChk("no stale latch", FAULT_BASE, 32'h0);
	endtask : tFreeze

	task automatic tFatal();
		logic [DATA_W-1:0] r;
		logic e;
		u_host.xfer(1'b0, 12'h020, '0, r, e);
		chk("unmapped", 32'(e), 32'h1);
		@(posedge clock) faultCond <= 128'h1 << 38;
		step(2);
		chk("comms off", 32'(commsEnable), 32'h0);
		u_host.xfer(1'b1, CTRL_OFS, 32'h1, r, e);
		chk("write refused", 32'(e), 32'h1);
		rdChk("fatal status", STATUS_OFS, 32'h3a);
		@(posedge clock) pdoWrite <= 1'b1;
		@(posedge clock) pdoWrite <= 1'b0;
		#1;
		chk("write accepted", 32'(pdoAccept), 32'h1);
	endtask : tFatal

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			badCount++;
			summarize();
		end
	end

	initial begin
		{resetn, alarmClearIn, hwPosOpen, hwNegOpen, swPosTrip, swNegTrip} = 6'h0;
		{targetSlot, targetRcvd, pdoRcvd, pdoWrite, pdoLength} = '0;
		{clockEnable, remoteEnable, pllLocked} = 3'h7;
		faultCond = '0;
		warnCond = '0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		step(1);
		tEnable();
		tWarn();
		tCodes();
		tFaultCmd();
		tRemote();
		tAlarm();
		tClearAll();
		tProcessData();
		tFreeze();
		tFatal();
		summarize();
	end
endmodule : fault_warning_manager_tb_top
